// *** logic/stap_pkg.sv ***
// package for the sram test access port: codes, sizes, id fields, tap states
package stap_pkg;
  localparam int STAP_IR_W = 3;
  localparam int STAP_BSR_W = 107;
  localparam int STAP_ID_W = 32;
  localparam int STAP_OE_CELL = 47;
  localparam int STAP_REV_W = 3;
  localparam int STAP_DEV_W = 17;
  localparam int STAP_VEN_W = 11;
  localparam logic [2:0] STAP_IR_EXTEST = 3'h0;
  localparam logic [2:0] STAP_IR_IDCODE = 3'h1;
  localparam logic [2:0] STAP_IR_SAMPLEZ = 3'h2;
  localparam logic [2:0] STAP_IR_SAMPLE = 3'h4;
  localparam logic [2:0] STAP_IR_BYPASS = 3'h7;
  // fixed low bits captured into the instruction shifter
  localparam logic [2:0] STAP_IR_CAPTURE = 3'h1;
  // arbitrary neutral identity values
  localparam logic [2:0] STAP_REV_DEF = 3'h0;
  localparam logic [16:0] STAP_DEV_DEF = 17'h00ABC;
  localparam logic [10:0] STAP_VEN_DEF = 11'h055;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } stap_state_t;

  // serial test pins from the controller
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } stap_pins_t;
endpackage

// *** logic/stap_core.sv ***
// tap logic: controller, instruction, bypass, id and boundary registers
`timescale 1ns/100ps
// Functional notes
// RQ1: 3-bit ir, 1 bypass, 32 id, 107 boundary
// RQ2: extest captures boundary ring into scan register
// RQ3: idcode loads id, routes it to tdo
// RQ4: code 010 captures pins, selects boundary register
// RQ5: code 010 forces data outputs high impedance
// RQ6: controller never loads codes 011, 101, 110; the ir register takes any shifted code at update-ir
// RQ7: sample/preload captures ring, selects boundary, harmless
// RQ8: bypass routes one-bit register, memory unaffected
// RQ9: cell 47 enables outputs under extest
// RQ10: cell 47 latch preset high at reset
// RQ11: id fields: revision, device, vendor, one
// RQ12: extest drives preloaded data onto pins
// RQ13: new instruction applies only at update-ir
// RQ14: test-logic-reset selects idcode instruction
module stap_core #(
  parameter int BSR_W = stap_pkg::STAP_BSR_W,
  // identity fields, values arbitrary
  parameter logic [2:0] REV_ID = stap_pkg::STAP_REV_DEF,
  parameter logic [16:0] DEV_ID = stap_pkg::STAP_DEV_DEF,
  parameter logic [10:0] VEN_ID = stap_pkg::STAP_VEN_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // test pins from the controller
  input wire stap_pkg::stap_pins_t pins,
  output logic tdo,
  output logic tdo_oe,
  // boundary ring, pins and core side
  input wire logic [BSR_W-1:0] ring_in,
  output logic [BSR_W-1:0] ring_out,
  output logic test_drive,
  // memory data output driver enable
  output logic q_oe
);
  import stap_pkg::*;

  logic [2:0] tck_s, tms_s, tdi_s;
  logic rise, fall, tms, tdi;
  stap_state_t state, next_state;
  logic [STAP_IR_W-1:0] ir, ir_sh;
  logic byp;
  logic [STAP_ID_W-1:0] id_sh;
  logic [BSR_W-1:0] bsr_sh, bsr_upd;
  logic ser_out;

  // pin synchronisers, third stage for edge find
  always_ff @(posedge clk) begin
    if (reset) begin
      tck_s <= 3'h0;
      tms_s <= 3'h0;
      tdi_s <= 3'h0;
    end else begin
      tck_s <= {tck_s[1:0], pins.tck};
      tms_s <= {tms_s[1:0], pins.tms};
      tdi_s <= {tdi_s[1:0], pins.tdi};
    end
  end
  assign rise = tck_s[1] & ~tck_s[2];
  assign fall = ~tck_s[1] & tck_s[2];
  assign tms = tms_s[1];
  assign tdi = tdi_s[1];

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: next_state = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: next_state = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_RESET;
    end else if (rise) begin
      state <= next_state;
    end
  end

  // RQ13 RQ14 instruction update
  always_ff @(posedge clk) begin
    if (reset) begin
      ir <= STAP_IR_IDCODE;
    end else if (state == ST_RESET) begin
      ir <= STAP_IR_IDCODE;
    end else if (state == ST_UPD_IR && fall) begin
      ir <= ir_sh;
    end
  end

  // RQ1 instruction shifter
  always_ff @(posedge clk) begin
    if (reset) begin
      ir_sh <= STAP_IR_CAPTURE;
    end else if (rise && state == ST_CAP_IR) begin
      ir_sh <= STAP_IR_CAPTURE;
    end else if (rise && state == ST_SH_IR) begin
      ir_sh <= {tdi, ir_sh[STAP_IR_W-1:1]};
    end
  end

  // RQ8 bypass bit
  always_ff @(posedge clk) begin
    if (reset) begin
      byp <= 1'b0;
    end else if (rise && state == ST_CAP_DR) begin
      byp <= 1'b0;
    end else if (rise && state == ST_SH_DR) begin
      byp <= tdi;
    end
  end

  // RQ3 RQ11 id capture and shift
  always_ff @(posedge clk) begin
    if (reset) begin
      id_sh <= 32'h0;
    end else if (rise && state == ST_CAP_DR && ir == STAP_IR_IDCODE) begin
      id_sh <= {REV_ID, DEV_ID, VEN_ID, 1'b1};
    end else if (rise && state == ST_SH_DR && ir == STAP_IR_IDCODE) begin
      id_sh <= {tdi, id_sh[STAP_ID_W-1:1]};
    end
  end

  // RQ2 RQ4 RQ7 boundary capture and shift
  always_ff @(posedge clk) begin
    if (reset) begin
      bsr_sh <= '0;
    end else if (rise && ir != STAP_IR_IDCODE && ir != STAP_IR_BYPASS) begin
      if (state == ST_CAP_DR) begin
        bsr_sh <= ring_in;
      end else if (state == ST_SH_DR) begin
        bsr_sh <= {tdi, bsr_sh[BSR_W-1:1]};
      end
    end
  end

  // RQ10 RQ12 update latch, cell 47 preset high
  always_ff @(posedge clk) begin
    if (reset || state == ST_RESET) begin
      bsr_upd <= BSR_W'(1) << STAP_OE_CELL;
    end else if (fall && state == ST_UPD_DR && ir != STAP_IR_IDCODE
                 && ir != STAP_IR_BYPASS) begin
      bsr_upd <= bsr_sh;
    end
  end

  always_comb begin
    unique case (state)
      ST_SH_IR: ser_out = ir_sh[0];
      default: begin
        if (ir == STAP_IR_IDCODE) ser_out = id_sh[0];
        else if (ir == STAP_IR_BYPASS) ser_out = byp;
        else ser_out = bsr_sh[0];
      end
    endcase
  end

  // tdo changes on falling tck edge
  always_ff @(posedge clk) begin
    if (reset) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (fall) begin
      tdo <= ser_out;
      tdo_oe <= (state == ST_SH_DR) || (state == ST_SH_IR);
    end
  end

  // RQ5 RQ9 RQ12 output driver control
  always_ff @(posedge clk) begin
    if (reset) begin
      ring_out <= '0;
      test_drive <= 1'b0;
      q_oe <= 1'b1;
    end else begin
      ring_out <= bsr_upd;
      test_drive <= (ir == STAP_IR_EXTEST);
      if (ir == STAP_IR_SAMPLEZ) q_oe <= 1'b0;
      else if (ir == STAP_IR_EXTEST) q_oe <= bsr_upd[STAP_OE_CELL];
      else q_oe <= 1'b1;
    end
  end

  // RQ5 high z under 010
  a_samplez_hiz: assert property (@(posedge clk) disable iff (reset)
    (ir == STAP_IR_SAMPLEZ) |=> !q_oe) else $error("q_oe high under sample z"); // RQ5
  a_reset_idcode: assert property (@(posedge clk) disable iff (reset)
    (state == ST_RESET) |=> (ir == STAP_IR_IDCODE)) else $error("reset lost idcode"); // RQ14
  a_ir_hold: assert property (@(posedge clk) disable iff (reset)
    (state == ST_SH_IR) |=> $stable(ir)) else $error("ir changed in shift"); // RQ13
  a_oe_preset: assert property (@(posedge clk) disable iff (reset)
    (state == ST_RESET) |=> bsr_upd[STAP_OE_CELL]) else $error("cell 47 not preset"); // RQ10
  a_extest_oe: assert property (@(posedge clk) disable iff (reset)
    (ir == STAP_IR_EXTEST) |=> (q_oe == $past(bsr_upd[STAP_OE_CELL])))
    else $error("extest oe mismatch"); // RQ9
  a_id_capture: assert property (@(posedge clk) disable iff (reset)
    (rise && state == ST_CAP_DR && ir == STAP_IR_IDCODE) |=> (id_sh[0] && id_sh[11:1] == VEN_ID))
    else $error("id capture wrong"); // RQ11
  a_byp_capture: assert property (@(posedge clk) disable iff (reset)
    (rise && state == ST_CAP_DR) |=> !byp) else $error("bypass capture not zero"); // RQ8
  a_bsr_capture: assert property (@(posedge clk) disable iff (reset)
    (rise && state == ST_CAP_DR && (ir == STAP_IR_SAMPLE || ir == STAP_IR_SAMPLEZ
     || ir == STAP_IR_EXTEST)) |=> (bsr_sh == $past(ring_in)))
    else $error("boundary capture wrong"); // RQ2
  a_drive_out: assert property (@(posedge clk) disable iff (reset)
    (ir == STAP_IR_EXTEST) ##1 (ir == STAP_IR_EXTEST) |-> test_drive)
    else $error("extest not driving"); // RQ12
  c_idcode_shift: cover property (@(posedge clk) state == ST_SH_DR && ir == STAP_IR_IDCODE);
  c_ir_update: cover property (@(posedge clk) state == ST_UPD_IR && fall);
  c_extest_hiz: cover property (@(posedge clk) ir == STAP_IR_EXTEST && !q_oe);
endmodule // stap_core

// *** tb/stap_ctl_model.sv ***
// test controller model: drives tck, tms, tdi and reads tdo
`timescale 1ns/100ps
module stap_ctl_model (
  // test pins
  output stap_pkg::stap_pins_t pins,
  input wire logic tdo,
  input wire logic tdo_oe
);
  import stap_pkg::*;
  // rises seen with the serial output enabled
  int oe_hits;
  initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};
  // one tck cycle, tck parked low between frames, tdo read at rise
  task automatic step(input logic ms, input logic di, output logic so);
    pins.tms = ms;
    pins.tdi = di;
    #24 pins.tck = 1'b1;
    so = tdo;
    if (tdo_oe) oe_hits++;
    #24 pins.tck = 1'b0;
  endtask
  task automatic go_reset();
    logic s;
    repeat (5) step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
  endtask
  task automatic ir_shift(input logic [2:0] code, output logic [2:0] cap);
    logic s;
    step(1'b1, 1'b0, s);
    step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
    step(1'b0, 1'b0, s);
    for (int i = 0; i < 3; i++) begin
      step(i == 2, code[i], cap[i]);
    end
  endtask
  task automatic ir_update();
    logic s;
    step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
  endtask
  task automatic dr_scan(input int n, input logic [STAP_BSR_W-1:0] din,
                         output logic [STAP_BSR_W-1:0] dout);
    logic s;
    dout = '0;
    oe_hits = 0;
    step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
    step(1'b0, 1'b0, s);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    ir_update();
  endtask
endmodule // stap_ctl_model

// *** tb/sram_test_access_port_decode_test.sv ***
// self-checking bench for the sram test access port
`timescale 1ns/100ps
module sram_test_access_port_decode_test;
  import stap_pkg::*;
  localparam logic [106:0] PAT_A = {3'h5, {13{8'h3C}}};
  localparam logic [106:0] PAT_B = {3'h2, {13{8'hD2}}};
  localparam logic [106:0] OE_BIT = 107'h1 << STAP_OE_CELL;
  localparam logic [31:0] ID_EXP = {STAP_REV_DEF, STAP_DEV_DEF, STAP_VEN_DEF, 1'b1};
  logic clk;
  logic reset;
  stap_pins_t pins;
  logic tdo;
  logic tdo_oe;
  logic [106:0] ring_in;
  logic [106:0] ring_out;
  logic test_drive;
  logic q_oe;
  logic [106:0] d;
  logic [2:0] c;
  int bad_count;
  int n_checks;
  stap_core dut (.clk(clk), .reset(reset), .pins(pins), .tdo(tdo), .tdo_oe(tdo_oe),
    .ring_in(ring_in), .ring_out(ring_out), .test_drive(test_drive), .q_oe(q_oe));
  stap_ctl_model ctl (.pins(pins), .tdo(tdo), .tdo_oe(tdo_oe));
  task automatic check(input logic [106:0] seen, input logic [106:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic load(input logic [2:0] code);
    ctl.ir_shift(code, c);
    check(c, STAP_IR_CAPTURE);
    ctl.ir_update();
  endtask
  task automatic t_idcode();
    check({test_drive, q_oe, ring_out[STAP_OE_CELL]}, 3'h3);
    ctl.step(1'b0, 1'b0, c[0]);
    ctl.dr_scan(32, '0, d);
    check(d, ID_EXP);
    check(ctl.oe_hits, 32);
  endtask
  task automatic t_bypass();
    load(STAP_IR_BYPASS);
    ctl.dr_scan(3, 107'h3, d);
    check(d, 107'h6);
    check(q_oe, 1'b1);
    load(STAP_IR_IDCODE);
    ctl.dr_scan(32, '0, d);
    check(d, ID_EXP);
    check(q_oe, 1'b1);
  endtask
  task automatic t_preload();
    @(negedge clk) ring_in = PAT_A;
    load(STAP_IR_SAMPLE);
    ctl.dr_scan(STAP_BSR_W, PAT_B & ~OE_BIT, d);
    check(d & ~OE_BIT, PAT_A & ~OE_BIT);
    check({test_drive, q_oe}, 2'h1);
    check(ring_out, PAT_B & ~OE_BIT);
  endtask
  task automatic t_samplez();
    @(negedge clk) ring_in = PAT_B;
    load(STAP_IR_SAMPLEZ);
    check(q_oe, 1'b0);
    ctl.dr_scan(STAP_BSR_W, PAT_A, d);
    check(d & ~OE_BIT, PAT_B & ~OE_BIT);
    ctl.ir_shift(STAP_IR_BYPASS, c);
    check(q_oe, 1'b0);
    ctl.ir_update();
    check(q_oe, 1'b1);
  endtask
  task automatic t_extest();
    @(negedge clk) ring_in = PAT_A;
    load(STAP_IR_EXTEST);
    check({test_drive, q_oe}, 2'h2);
    check(ring_out, PAT_A);
    ctl.dr_scan(STAP_BSR_W, PAT_B, d);
    check(d & ~OE_BIT, PAT_A & ~OE_BIT);
    check(q_oe, 1'b1);
    check(ring_out, PAT_B);
  endtask
  task automatic t_tms_reset();
    ctl.go_reset();
    check({test_drive, q_oe, ring_out[STAP_OE_CELL]}, 3'h3);
    ctl.dr_scan(32, '0, d);
    check(d, ID_EXP);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    ring_in = '0;
    bad_count = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    repeat (4) @(negedge clk);
    #0.3;
    t_idcode();
    t_bypass();
    t_preload();
    t_samplez();
    t_extest();
    t_tms_reset();
    wrap_up();
  end
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule // sram_test_access_port_decode_test
